// *** stc_regs_cfg.svh ***
// offsets, field positions, reset values and write masks of the tuning register group
// assumes inclusion by bare name from the package and the register bank
`ifndef STC_REGS_CFG_SVH
`define STC_REGS_CFG_SVH

`define STC_OFS_SCRATCH 8'h6c
`define STC_OFS_TIMER 8'h70
`define STC_OFS_MODE 8'h74

`define STC_RST_SCRATCH 32'h04000800
`define STC_RST_TIMER 32'h80000000
// upstream power-management field default is arbitrary (zero)
`define STC_RST_MODE_UP 32'h0a730002
`define STC_RST_MODE_DN 32'h0a730102
// enabled edges the strap stages need after reset before a capture
`define STC_STRAP_FILL_END 2'h3

`define STC_CFG_MASK_SCRATCH 32'hffffffff
`define STC_CFG_MASK_TIMER 32'h7fff1fff
`define STC_CFG_MASK_MODE 32'h00003f7f
`define STC_SIDE_MASK_SCRATCH 32'hffffffff
`define STC_SIDE_MASK_TIMER 32'hffff7fff
`define STC_SIDE_MASK_MODE 32'h7fffff7f

`define STC_TMR_REPLAY_HI 11
`define STC_TMR_REPLAY_LO 0
`define STC_TMR_REPLAY_EN 12
`define STC_TMR_PM_CAP_DIS 13
`define STC_TMR_MSI_CAP_DIS 14
`define STC_TMR_RSVD 15
`define STC_TMR_ACK_HI 29
`define STC_TMR_ACK_LO 16
`define STC_TMR_ACK_EN 30
`define STC_TMR_VGA 31

`define STC_MODE_STORE_FWD 0
`define STC_MODE_CT_HI 2
`define STC_MODE_CT_LO 1
`define STC_MODE_ARB_HOLD 3
`define STC_MODE_CREDIT_ALL 4
`define STC_MODE_ORD_EGRESS 5
`define STC_MODE_ORD_TAG 6
`define STC_MODE_RSVD_LO 7
`define STC_MODE_PM_HI 13
`define STC_MODE_PM_LO 8
`define STC_MODE_RXPOL 14
`define STC_MODE_PARITY 15
`define STC_MODE_DRV_LOW_HI 20
`define STC_MODE_DRV_LOW_LO 16
`define STC_MODE_DRV_HIGH_HI 25
`define STC_MODE_DRV_HIGH_LO 21
`define STC_MODE_DRV_HALF_HI 30
`define STC_MODE_DRV_HALF_LO 26
`define STC_MODE_RSVD_HI 31

`endif

// *** stc_regs_pkg.sv ***
// types shared by the tuning register group and its users
// assumes the constants header is on the include path
package stc_regs_pkg;
`include "stc_regs_cfg.svh"

	// one register access: configuration space or side-channel load
	typedef struct packed {
		logic req;
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} stc_access_type;

	// controls consumed by the link layer
	typedef struct packed {
		logic [11:0] replay_timeout_value;
		logic replay_use_user;
		logic [13:0] ack_latency_value;
		logic ack_use_user;
		logic vga_decode_en;
		logic pm_cap_disable;
		logic msi_cap_disable;
	} stc_link_ctrl_type;

	// controls consumed by the forwarding, arbiter, credit and phy logic
	typedef struct packed {
		logic store_forward;
		logic [1:0] cut_through_advance;
		logic arb_hold_on_grant;
		logic credit_all_types;
		logic order_egress;
		logic order_cpl_tag;
		logic [5:0] pm_ctrl_param;
		logic rx_polarity_flip_off_strap;
		logic parity_ctrl_disable;
		logic [4:0] drive_level_low_deemph;
		logic [4:0] drive_level_high_deemph;
		logic [4:0] drive_level_half_swing;
	} stc_switch_ctrl_type;

endpackage

// *** stc_tuning_regs.sv ***
// tuning register group of a switch port: scratch word, timer overrides and operation mode word
// assumes a configuration-space agent presenting one dword access per request and a side-channel
// loader (smbus or eeprom autoload) that may rewrite every non-reserved bit, read-only ones too
//
// Overview of operation
// RL1: 12-bit replay time-out value, rw, resets zero
// RL2: override bit selects user replay time-out
// RL3: 14-bit ack latency value, rw, resets zero
// RL4: override bit selects user ack latency
// RL5: read-only vga decode flag, resets one
// RL6: side channel may rewrite all defaults
// RL7: mode bit picks store-forward over cut-through
// RL8: threshold moves cut-through start 0-3 cycles earlier
// RL9: arbitration bit set holds grant while requesting
// RL10: bit clear moves only to credited requester
// RL11: credit bit set releases all types together
// RL12: credit bit clear releases per credit type
// RL13: egress bit enforces cross-port ordering
// RL14: tag bit enforces ordering across completion tags
// RL15: downstream copy: pm default one, strap polarity
// RL16: reserved bits read zero, writes ignored
`timescale 1ns/10ps
`include "stc_regs_cfg.svh"

module stc_tuning_regs #(
	parameter bit downstream_port = 1'b0
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic cfg_clk_en,
	input wire stc_regs_pkg::stc_access_type cfg_in,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	input wire stc_regs_pkg::stc_access_type side_in,
	input wire logic rx_polarity_strap_pin,
	output stc_regs_pkg::stc_link_ctrl_type link_ctrl,
	output stc_regs_pkg::stc_switch_ctrl_type switch_ctrl
);
	import stc_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////////////////
	// storage and helpers

	localparam logic [31:0] mode_reset = downstream_port ? `STC_RST_MODE_DN : `STC_RST_MODE_UP;

	logic [31:0] scratch;
	logic [31:0] timer;
	logic [31:0] mode;
	logic strap_ff1;
	logic strap_ff2;
	logic strap_ff3;
	logic strap_taken;

	// byte-lane merge limited to the bits the writer may touch
	function automatic logic [31:0] stc_merge(input logic [31:0] old, input logic [31:0] wdata,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] lane;
		lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
		return (old & ~lane) | (wdata & lane);
	endfunction

	logic cfg_wr_scratch;
	logic cfg_wr_timer;
	logic cfg_wr_mode;
	logic side_wr_scratch;
	logic side_wr_timer;
	logic side_wr_mode;

	always_comb
	begin
		cfg_wr_scratch = cfg_in.req && cfg_in.wr && (cfg_in.addr == `STC_OFS_SCRATCH);
		cfg_wr_timer = cfg_in.req && cfg_in.wr && (cfg_in.addr == `STC_OFS_TIMER);
		cfg_wr_mode = cfg_in.req && cfg_in.wr && (cfg_in.addr == `STC_OFS_MODE);
		side_wr_scratch = side_in.req && side_in.wr && (side_in.addr == `STC_OFS_SCRATCH);
		side_wr_timer = side_in.req && side_in.wr && (side_in.addr == `STC_OFS_TIMER);
		side_wr_mode = side_in.req && side_in.wr && (side_in.addr == `STC_OFS_MODE);
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// scratch word

	// a side-channel load in the same cycle takes the register; the configuration write is dropped
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			scratch <= `STC_RST_SCRATCH;
		else if (cfg_clk_en)
		begin
			if (side_wr_scratch)
				scratch <= stc_merge(scratch, side_in.wdata, side_in.be, `STC_SIDE_MASK_SCRATCH); // [RL6]
			else if (cfg_wr_scratch)
				scratch <= stc_merge(scratch, cfg_in.wdata, cfg_in.be, `STC_CFG_MASK_SCRATCH);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// timer override word

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			timer <= `STC_RST_TIMER; // [RL1] [RL3] [RL5]
		else if (cfg_clk_en)
		begin
			if (side_wr_timer)
				timer <= stc_merge(timer, side_in.wdata, side_in.be, `STC_SIDE_MASK_TIMER); // [RL6] [RL16]
			else if (cfg_wr_timer)
				timer <= stc_merge(timer, cfg_in.wdata, cfg_in.be, `STC_CFG_MASK_TIMER); // [RL1] [RL3] [RL16]
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// receive polarity strap: three stages, taken once the last two agree after reset

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			strap_ff1 <= 1'b0;
			strap_ff2 <= 1'b0;
			strap_ff3 <= 1'b0;
		end
		else if (cfg_clk_en)
		begin
			strap_ff1 <= rx_polarity_strap_pin;
			strap_ff2 <= strap_ff1;
			strap_ff3 <= strap_ff2;
		end
	end

	logic strap_load;
	assign strap_load = downstream_port && !strap_taken && (strap_ff2 == strap_ff3);

	// three edges are needed so the last stage holds the pin before capture
	logic [1:0] strap_fill;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			strap_fill <= 2'h0;
		else if (cfg_clk_en && (strap_fill != `STC_STRAP_FILL_END))
			strap_fill <= strap_fill + 2'h1;
	end

	logic strap_capture;
	assign strap_capture = strap_load && (strap_fill == `STC_STRAP_FILL_END);

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			strap_taken <= 1'b0;
		else if (cfg_clk_en && strap_capture)
			strap_taken <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// operation mode word

	logic [31:0] next_mode;

	always_comb
	begin
		next_mode = mode;
		if (side_wr_mode)
			next_mode = stc_merge(mode, side_in.wdata, side_in.be, `STC_SIDE_MASK_MODE); // [RL6] [RL16]
		else if (cfg_wr_mode)
			next_mode = stc_merge(mode, cfg_in.wdata, cfg_in.be, `STC_CFG_MASK_MODE); // [RL7] [RL16]
		// strap sets the default; a later side-channel load may still replace it
		if (strap_capture && !(side_wr_mode && side_in.be[1]))
			next_mode[`STC_MODE_RXPOL] = strap_ff3; // [RL15]
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			mode <= mode_reset; // [RL7] [RL8] [RL15]
		else if (cfg_clk_en)
			mode <= next_mode;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// configuration-space read and answer

	logic [31:0] next_rdata;

	always_comb
	begin
		case (cfg_in.addr)
			`STC_OFS_SCRATCH: next_rdata = scratch;
			`STC_OFS_TIMER: next_rdata = timer;
			`STC_OFS_MODE: next_rdata = mode;
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h00000000;
		end
		else if (cfg_clk_en)
		begin
			cfg_ack <= cfg_in.req;
			if (cfg_in.req && !cfg_in.wr)
				cfg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// controls to the rest of the switch, straight from the register bits

	always_comb
	begin
		link_ctrl.replay_timeout_value = timer[`STC_TMR_REPLAY_HI:`STC_TMR_REPLAY_LO]; // [RL1]
		link_ctrl.replay_use_user = timer[`STC_TMR_REPLAY_EN]; // [RL2]
		link_ctrl.ack_latency_value = timer[`STC_TMR_ACK_HI:`STC_TMR_ACK_LO]; // [RL3]
		link_ctrl.ack_use_user = timer[`STC_TMR_ACK_EN]; // [RL4]
		link_ctrl.vga_decode_en = timer[`STC_TMR_VGA]; // [RL5]
		link_ctrl.pm_cap_disable = timer[`STC_TMR_PM_CAP_DIS];
		link_ctrl.msi_cap_disable = timer[`STC_TMR_MSI_CAP_DIS];
		switch_ctrl.store_forward = mode[`STC_MODE_STORE_FWD]; // [RL7]
		switch_ctrl.cut_through_advance = mode[`STC_MODE_CT_HI:`STC_MODE_CT_LO]; // [RL8]
		switch_ctrl.arb_hold_on_grant = mode[`STC_MODE_ARB_HOLD]; // [RL9] [RL10]
		switch_ctrl.credit_all_types = mode[`STC_MODE_CREDIT_ALL]; // [RL11] [RL12]
		switch_ctrl.order_egress = mode[`STC_MODE_ORD_EGRESS]; // [RL13]
		switch_ctrl.order_cpl_tag = mode[`STC_MODE_ORD_TAG]; // [RL14]
		switch_ctrl.pm_ctrl_param = mode[`STC_MODE_PM_HI:`STC_MODE_PM_LO]; // [RL15]
		switch_ctrl.rx_polarity_flip_off_strap = mode[`STC_MODE_RXPOL]; // [RL15]
		switch_ctrl.parity_ctrl_disable = mode[`STC_MODE_PARITY];
		switch_ctrl.drive_level_low_deemph = mode[`STC_MODE_DRV_LOW_HI:`STC_MODE_DRV_LOW_LO];
		switch_ctrl.drive_level_high_deemph = mode[`STC_MODE_DRV_HIGH_HI:`STC_MODE_DRV_HIGH_LO];
		switch_ctrl.drive_level_half_swing = mode[`STC_MODE_DRV_HALF_HI:`STC_MODE_DRV_HALF_LO];
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// checks

	a_replay_value_write: assert property (@(posedge mclk) disable iff (!resetn) // [RL1]
		(cfg_clk_en && cfg_wr_timer && !side_wr_timer && (cfg_in.be[1:0] == 2'h3))
		|=> (link_ctrl.replay_timeout_value == $past(cfg_in.wdata[11:0])))
		else $error("replay time-out value not taken from write");

	a_replay_use_user: assert property (@(posedge mclk) disable iff (!resetn) // [RL2]
		(cfg_clk_en && cfg_wr_timer && !side_wr_timer && cfg_in.be[1])
		|=> (link_ctrl.replay_use_user == $past(cfg_in.wdata[12])))
		else $error("replay override bit not taken from write");

	a_ack_value_write: assert property (@(posedge mclk) disable iff (!resetn) // [RL3]
		(cfg_clk_en && cfg_wr_timer && !side_wr_timer && (cfg_in.be[3:2] == 2'h3))
		|=> (link_ctrl.ack_latency_value == $past(cfg_in.wdata[29:16])))
		else $error("ack latency value not taken from write");

	a_ack_use_user: assert property (@(posedge mclk) disable iff (!resetn) // [RL4]
		(cfg_clk_en && cfg_wr_timer && !side_wr_timer && cfg_in.be[3])
		|=> (link_ctrl.ack_use_user == $past(cfg_in.wdata[30])))
		else $error("ack override bit not taken from write");

	a_vga_read_only: assert property (@(posedge mclk) disable iff (!resetn) // [RL5]
		(cfg_clk_en && !side_wr_timer) |=> $stable(link_ctrl.vga_decode_en))
		else $error("vga decode flag changed without side-channel load");

	a_side_load_ro: assert property (@(posedge mclk) disable iff (!resetn) // [RL6]
		(cfg_clk_en && side_wr_mode && side_in.be[2])
		|=> (switch_ctrl.drive_level_low_deemph == $past(side_in.wdata[20:16])))
		else $error("side-channel load missed a read-only field");

	a_forward_mode: assert property (@(posedge mclk) disable iff (!resetn) // [RL7]
		(cfg_clk_en && cfg_wr_mode && !side_wr_mode && cfg_in.be[0])
		|=> (switch_ctrl.store_forward == $past(cfg_in.wdata[0]))
		&& (switch_ctrl.cut_through_advance == $past(cfg_in.wdata[2:1])))
		else $error("forwarding mode fields not taken from write");

	a_strap_capture: assert property (@(posedge mclk) disable iff (!resetn) // [RL15]
		(cfg_clk_en && strap_capture && !side_wr_mode)
		|=> (switch_ctrl.rx_polarity_flip_off_strap == $past(strap_ff3)) && strap_taken)
		else $error("strap not captured into polarity bit");

	a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn) // [RL16]
		!timer[`STC_TMR_RSVD] && !mode[`STC_MODE_RSVD_LO] && !mode[`STC_MODE_RSVD_HI])
		else $error("reserved bit reads as one");

	a_read_answer: assert property (@(posedge mclk) disable iff (!resetn) // [RL16]
		(cfg_clk_en && cfg_in.req && !cfg_in.wr && (cfg_in.addr == `STC_OFS_MODE))
		|=> cfg_ack && (cfg_rdata == $past(mode)))
		else $error("mode word read answer wrong");

	a_freeze_enable: assert property (@(posedge mclk) disable iff (!resetn)
		!cfg_clk_en |=> $stable(scratch) && $stable(timer) && $stable(mode) && $stable(cfg_ack))
		else $error("state moved while clock enable low");

	a_ack_idle: assert property (@(posedge mclk) disable iff (!resetn)
		(cfg_clk_en && !cfg_in.req) |=> !cfg_ack)
		else $error("answer without request");

	a_read_timer: assert property (@(posedge mclk) disable iff (!resetn) // [RL1] [RL3]
		(cfg_clk_en && cfg_in.req && !cfg_in.wr && (cfg_in.addr == `STC_OFS_TIMER))
		|=> cfg_ack && (cfg_rdata == $past(timer)))
		else $error("timer word read answer wrong");

	a_arb_mode_write: assert property (@(posedge mclk) disable iff (!resetn) // [RL9] [RL10]
		(cfg_clk_en && cfg_wr_mode && !side_wr_mode && cfg_in.be[0])
		|=> (switch_ctrl.arb_hold_on_grant == $past(cfg_in.wdata[`STC_MODE_ARB_HOLD])))
		else $error("arbitration mode bit not taken from write");

	a_credit_mode_write: assert property (@(posedge mclk) disable iff (!resetn) // [RL11] [RL12]
		(cfg_clk_en && cfg_wr_mode && !side_wr_mode && cfg_in.be[0])
		|=> (switch_ctrl.credit_all_types == $past(cfg_in.wdata[`STC_MODE_CREDIT_ALL])))
		else $error("credit update bit not taken from write");

	a_egress_order_write: assert property (@(posedge mclk) disable iff (!resetn) // [RL13]
		(cfg_clk_en && cfg_wr_mode && !side_wr_mode && cfg_in.be[0])
		|=> (switch_ctrl.order_egress == $past(cfg_in.wdata[`STC_MODE_ORD_EGRESS])))
		else $error("egress ordering bit not taken from write");

	a_tag_order_write: assert property (@(posedge mclk) disable iff (!resetn) // [RL14]
		(cfg_clk_en && cfg_wr_mode && !side_wr_mode && cfg_in.be[0])
		|=> (switch_ctrl.order_cpl_tag == $past(cfg_in.wdata[`STC_MODE_ORD_TAG])))
		else $error("completion tag ordering bit not taken from write");

	a_timer_ro_kept: assert property (@(posedge mclk) disable iff (!resetn) // [RL6]
		!side_wr_timer |=> $stable(link_ctrl.pm_cap_disable) && $stable(link_ctrl.msi_cap_disable))
		else $error("read-only timer bit changed without side-channel load");

	a_mode_ro_kept: assert property (@(posedge mclk) disable iff (!resetn) // [RL6]
		!side_wr_mode |=> $stable(switch_ctrl.parity_ctrl_disable)
		&& $stable(switch_ctrl.drive_level_low_deemph) && $stable(switch_ctrl.drive_level_high_deemph)
		&& $stable(switch_ctrl.drive_level_half_swing))
		else $error("read-only mode field changed without side-channel load");

	a_polarity_kept: assert property (@(posedge mclk) disable iff (!resetn) // [RL15]
		(!side_wr_mode && !strap_capture) |=> $stable(switch_ctrl.rx_polarity_flip_off_strap))
		else $error("polarity bit changed without strap or side-channel load");

	a_unmapped_ignored: assert property (@(posedge mclk) disable iff (!resetn) // [RL16]
		(cfg_in.req && cfg_in.wr && !cfg_wr_scratch && !cfg_wr_timer && !cfg_wr_mode && !side_in.req && !strap_capture)
		|=> $stable(scratch) && $stable(timer) && $stable(mode))
		else $error("unmapped write changed a register");

	a_side_wins: assert property (@(posedge mclk) disable iff (!resetn) // [RL6]
		(cfg_clk_en && side_wr_scratch && cfg_wr_scratch && (side_in.be == 4'hf))
		|=> (scratch == $past(side_in.wdata)))
		else $error("side-channel load lost a same-cycle collision");

endmodule // stc_tuning_regs

// *** stc_tuning_regs_test.sv ***
// self-checking bench of the tuning register group: reset values, write masks, side loads, collisions
// assumes the package and its constants header are compiled first; one upstream and one downstream instance
`timescale 1ns/10ps

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module stc_tuning_regs_test;
	import stc_regs_pkg::*;

	logic mclk, resetn, cfg_clk_en, rx_polarity_strap_pin, cfg_ack;
	logic [31:0] cfg_rdata, rd;
	stc_access_type cfg_in, side_in;
	stc_link_ctrl_type link_ctrl;
	stc_switch_ctrl_type switch_ctrl;
	logic [31:0] cfg_rdata_dn;
	stc_switch_ctrl_type switch_ctrl_dn;
	int n_mismatch, compares;

	stc_tuning_regs #(.downstream_port(1'b0)) i_dut (.mclk(mclk), .resetn(resetn), .cfg_clk_en(cfg_clk_en),
		.cfg_in(cfg_in), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .side_in(side_in),
		.rx_polarity_strap_pin(rx_polarity_strap_pin), .link_ctrl(link_ctrl), .switch_ctrl(switch_ctrl));

	// downstream copy: same stimulus, strap capture and its own mode default
	stc_tuning_regs #(.downstream_port(1'b1)) i_dut_dn (.mclk(mclk), .resetn(resetn), .cfg_clk_en(cfg_clk_en),
		.cfg_in(cfg_in), .cfg_ack(), .cfg_rdata(cfg_rdata_dn), .side_in(side_in),
		.rx_polarity_strap_pin(rx_polarity_strap_pin), .link_ctrl(), .switch_ctrl(switch_ctrl_dn));

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// releases both requests after the taking edge, then waits a bounded time for the answer
	task automatic wait_ack(output logic [31:0] data);
		int i;
		for (i = 0; i < 4; i++)
		begin
			@(posedge mclk);
			#1;
			cfg_in.req = 1'b0;
			side_in.req = 1'b0;
			if (cfg_ack === 1'b1)
				break;
		end
		data = cfg_rdata;
		if (i == 4)
		begin
			n_mismatch++;
			$display("mismatch at %0t: no answer", $time);
			finish_test();
		end
	endtask

	task automatic cfg_op(input logic wr, input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wdata,
		output logic [31:0] data);
		@(posedge mclk);
		#1;
		cfg_in = '{req: 1'b1, wr: wr, addr: addr, be: be, wdata: wdata};
		wait_ack(data);
	endtask

	task automatic side_wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wdata);
		@(posedge mclk);
		#1;
		side_in = '{req: 1'b1, wr: 1'b1, addr: addr, be: be, wdata: wdata};
		@(posedge mclk);
		#1;
		side_in.req = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset;
		cfg_op(1'b0, 8'h6c, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h04000800)
		@(posedge mclk);
		#1;
		`CHK(cfg_ack, 1'b0)
		cfg_op(1'b0, 8'h70, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h80000000)
		cfg_op(1'b0, 8'h74, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h0a730002)
		`CHK(cfg_rdata_dn, 32'h0a734102)
		`CHK(switch_ctrl_dn.pm_ctrl_param, 6'h01)
		`CHK(switch_ctrl_dn.rx_polarity_flip_off_strap, 1'b1)
		`CHK(switch_ctrl.rx_polarity_flip_off_strap, 1'b0)
		`CHK(switch_ctrl.pm_ctrl_param, 6'h00)
		`CHK(switch_ctrl.parity_ctrl_disable, 1'b0)
		`CHK(switch_ctrl.drive_level_low_deemph, 5'h13)
		`CHK(switch_ctrl.drive_level_high_deemph, 5'h13)
		`CHK(switch_ctrl.drive_level_half_swing, 5'h02)
		`CHK(link_ctrl.pm_cap_disable, 1'b0)
		`CHK(link_ctrl.msi_cap_disable, 1'b0)
		`CHK(link_ctrl.vga_decode_en, 1'b1)
		`CHK(switch_ctrl.cut_through_advance, 2'b01)
	endtask

	task automatic test_timer;
		cfg_op(1'b1, 8'h70, 4'hf, 32'hffffffff, rd);
		`CHK(link_ctrl.replay_timeout_value, 12'hfff)
		`CHK(link_ctrl.replay_use_user, 1'b1)
		`CHK(link_ctrl.ack_latency_value, 14'h3fff)
		`CHK(link_ctrl.ack_use_user, 1'b1)
		cfg_op(1'b0, 8'h70, 4'hf, 32'h0, rd);
		`CHK(rd, 32'hffff1fff)
		cfg_op(1'b1, 8'h70, 4'b0100, 32'h0, rd);
		`CHK(link_ctrl.ack_latency_value, 14'h3f00)
		cfg_op(1'b1, 8'h70, 4'hf, 32'h0, rd);
		cfg_op(1'b0, 8'h70, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h80000000)
	endtask

	task automatic test_mode;
		cfg_op(1'b1, 8'h74, 4'hf, 32'hffffffff, rd);
		cfg_op(1'b0, 8'h74, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h0a733f7f)
		`CHK(switch_ctrl.store_forward, 1'b1)
		`CHK(switch_ctrl.arb_hold_on_grant, 1'b1)
		`CHK(switch_ctrl.credit_all_types, 1'b1)
		`CHK(switch_ctrl.order_egress, 1'b1)
		`CHK(switch_ctrl.order_cpl_tag, 1'b1)
		for (int code = 0; code < 4; code++)
		begin
			cfg_op(1'b1, 8'h74, 4'b0001, {29'h0, code[1:0], 1'b0}, rd);
			`CHK(switch_ctrl.cut_through_advance, code[1:0])
			`CHK(switch_ctrl.store_forward, 1'b0)
			`CHK(switch_ctrl.arb_hold_on_grant, 1'b0)
			`CHK(switch_ctrl.credit_all_types, 1'b0)
		end
		`CHK(switch_ctrl.pm_ctrl_param, 6'h3f)
	endtask

	task automatic test_side;
		side_wr(8'h70, 4'hf, 32'h7fffffff);
		`CHK(link_ctrl.vga_decode_en, 1'b0)
		`CHK(link_ctrl.pm_cap_disable, 1'b1)
		`CHK(link_ctrl.msi_cap_disable, 1'b1)
		cfg_op(1'b0, 8'h70, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h7fff7fff)
		side_wr(8'h74, 4'b0100, 32'h00150000);
		`CHK(switch_ctrl.drive_level_low_deemph, 5'h15)
		side_wr(8'h74, 4'hf, 32'hffffffff);
		`CHK(switch_ctrl.parity_ctrl_disable, 1'b1)
		`CHK(switch_ctrl.drive_level_high_deemph, 5'h1f)
		`CHK(switch_ctrl.drive_level_half_swing, 5'h1f)
		`CHK(switch_ctrl.rx_polarity_flip_off_strap, 1'b1)
		cfg_op(1'b0, 8'h74, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h7fffff7f)
	endtask

	task automatic test_unmapped_collision;
		cfg_op(1'b1, 8'h00, 4'hf, 32'hffffffff, rd);
		cfg_op(1'b0, 8'h00, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h0)
		cfg_op(1'b1, 8'h6c, 4'b0001, 32'hffffffaa, rd);
		cfg_op(1'b0, 8'h6c, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h040008aa)
		// side load and configuration write to one register in one cycle: side load wins
		@(posedge mclk);
		#1;
		side_in = '{req: 1'b1, wr: 1'b1, addr: 8'h6c, be: 4'hf, wdata: 32'h22222222};
		cfg_in = '{req: 1'b1, wr: 1'b1, addr: 8'h6c, be: 4'hf, wdata: 32'h11111111};
		wait_ack(rd);
		cfg_op(1'b0, 8'h6c, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h22222222)
		// a request while the clock enable is low is not taken
		@(posedge mclk);
		#1;
		cfg_clk_en = 1'b0;
		cfg_in = '{req: 1'b1, wr: 1'b0, addr: 8'h6c, be: 4'hf, wdata: 32'h0};
		repeat (2) @(posedge mclk);
		#1;
		`CHK(cfg_ack, 1'b0)
		cfg_in.req = 1'b0;
		cfg_clk_en = 1'b1;
	endtask

	task automatic test_second_reset;
		@(posedge mclk);
		#1;
		resetn = 1'b0;
		rx_polarity_strap_pin = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		resetn = 1'b1;
		cfg_op(1'b0, 8'h70, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h80000000)
		cfg_op(1'b0, 8'h74, 4'hf, 32'h0, rd);
		`CHK(rd, 32'h0a730002)
		`CHK(cfg_rdata_dn, 32'h0a730102)
		`CHK(switch_ctrl_dn.rx_polarity_flip_off_strap, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		n_mismatch = 0;
		compares = 0;
		resetn = 1'b0;
		cfg_clk_en = 1'b1;
		rx_polarity_strap_pin = 1'b1;
		cfg_in = '0;
		side_in = '0;
		repeat (6) @(posedge mclk);
		#1;
		resetn = 1'b1;
		test_reset();
		test_timer();
		test_mode();
		test_side();
		test_unmapped_collision();
		test_second_reset();
		finish_test();
	end
endmodule // stc_tuning_regs_test
